// ===== src/ptm_pkg.sv
package ptm_pkg;
    typedef struct packed {
        logic [3:0] post_divide_select;
        logic count_run_enable;
        logic [1:0] pre_divide_select;
    } ptm_ctl_s;

    typedef enum logic [1:0] {
        PTM_RESP_OKAY = 2'b00,
        PTM_RESP_SLVERR = 2'b10
    } ptm_resp_e;
endpackage

// ===== src/ptm_regs.svh
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH

`define PTM_OFS_CONTROL 12'h000
`define PTM_OFS_COUNT 12'h004
`define PTM_OFS_PERIOD 12'h008
`define PTM_OFS_IRQ_STATUS 12'h00c
`define PTM_OFS_IRQ_MASK 12'h010

`define PTM_CTL_PRE_LSB 0
`define PTM_CTL_RUN_BIT 2
`define PTM_CTL_POST_LSB 3
`define PTM_CTL_IMPL_MASK 8'h7f

`define PTM_RST_CONTROL 8'h00
`define PTM_RST_COUNT 8'h00
`define PTM_RST_PERIOD 8'hff

`define PTM_PRE_DIV4_LAST 6'h03
`define PTM_PRE_DIV16_LAST 6'h0f
`define PTM_PRE_DIV64_LAST 6'h3f
`define PTM_INSTR_CLK_DIV 2

`define PTM_IRQ_MATCH_BIT 0

`endif

// ===== src/ptm_scaler.sv
`timescale 1ns/1ns
`include "ptm_regs.svh"
// counter for the prescaler only: tick generator from the decoded terminal count i_last
module ptm_scaler
    import ptm_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_clr,
    input wire logic i_en,
    input wire logic [WIDTH-1:0] i_last,
    output logic o_tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        o_tick = 1'b0;
        if (i_en) begin
            if (cnt_q >= i_last) begin
                cnt_d = '0;
                o_tick = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        if (i_clr) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ===== src/ptm_timer.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ptm_regs.svh"
// Overview of operation
// R1: control bit 7 is unimplemented, reads zero, writes ignored.
// R2: prescale field bits 1-0 divides timer clock by 1, 4, 16, 64.
// R3: all implemented control bits read/write and clear on every reset.
// R4: eight-bit count register readable and writable, plus eight-bit period register.
// R5: run enable bit 2 advances count per prescaled clock; zero holds.
// R6: postscale bits 6-3 raise match flag every N matches, N=code+1.
// R7: count equal to period gives match pulse, count reloads zero next tick.
// R8: count or control write clears prescaler and postscaler; control write keeps count.
// R9: reset clears count to zero and sets period to all ones.
module ptm_timer
    import ptm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_period_match_pulse,
    output logic o_irq
);
    // ==========================================================
    // register bus
    logic aw_hold_q, aw_hold_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic w_hold_q, w_hold_d;
    logic [31:0] w_data_q, w_data_d;
    logic w_lane0_q, w_lane0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go;
    logic [7:0] wr_byte;

    ptm_ctl_s ctl_q, ctl_d;
    logic [7:0] count_value_q, count_value_d;
    logic [7:0] period_value_q, period_value_d;
    logic match_event_flag_q, match_event_flag_d;
    logic flag_set;
    logic match_event_enable_q, match_event_enable_d;
    logic [3:0] post_cnt_q, post_cnt_d;
    logic instr_phase_q, instr_phase_d;
    logic match_pend_q, match_pend_d;
    logic pulse_q, pulse_d;
    logic wr_ctl, wr_cnt, wr_per, wr_sts, wr_msk;
    logic scaler_clr, pre_tick;
    logic [5:0] pre_last;

    assign o_awready = !aw_hold_q;
    assign o_wready = !w_hold_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = rdata_q;

    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_byte = w_data_q[7:0];
    assign wr_ctl = wr_go && w_lane0_q && aw_addr_q == `PTM_OFS_CONTROL;
    assign wr_cnt = wr_go && w_lane0_q && aw_addr_q == `PTM_OFS_COUNT;
    assign wr_per = wr_go && w_lane0_q && aw_addr_q == `PTM_OFS_PERIOD;
    assign wr_sts = wr_go && w_lane0_q && aw_addr_q == `PTM_OFS_IRQ_STATUS;
    assign wr_msk = wr_go && w_lane0_q && aw_addr_q == `PTM_OFS_IRQ_MASK;

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = a == `PTM_OFS_CONTROL || a == `PTM_OFS_COUNT || a == `PTM_OFS_PERIOD
            || a == `PTM_OFS_IRQ_STATUS || a == `PTM_OFS_IRQ_MASK;
    endfunction

    always_comb begin
        aw_hold_d = aw_hold_q;
        aw_addr_d = aw_addr_q;
        w_hold_d = w_hold_q;
        w_data_d = w_data_q;
        w_lane0_d = w_lane0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (i_awvalid && !aw_hold_q) begin
            aw_hold_d = 1'b1;
            aw_addr_d = {i_awaddr[11:2], 2'b00};
        end
        if (i_wvalid && !w_hold_q) begin
            w_hold_d = 1'b1;
            w_data_d = i_wdata;
            w_lane0_d = i_wstrb[0];
        end
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(aw_addr_q) ? PTM_RESP_OKAY : PTM_RESP_SLVERR;
        end else if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // reads sample live state; one cycle from address to data
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (i_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = PTM_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case ({i_araddr[11:2], 2'b00})
                `PTM_OFS_CONTROL: rdata_d[7:0] = {1'b0, ctl_q}; // [R1] [R3]
                `PTM_OFS_COUNT: rdata_d[7:0] = count_value_q; // [R4]
                `PTM_OFS_PERIOD: rdata_d[7:0] = period_value_q; // [R4]
                `PTM_OFS_IRQ_STATUS: rdata_d[`PTM_IRQ_MATCH_BIT] = match_event_flag_q;
                `PTM_OFS_IRQ_MASK: rdata_d[`PTM_IRQ_MATCH_BIT] = match_event_enable_q;
                default: rresp_d = PTM_RESP_SLVERR;
            endcase
        end else if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rresp_q <= 2'b00;
            rdata_q <= 32'h0000_0000;
        end else begin
            aw_hold_q <= aw_hold_d;
            aw_addr_q <= aw_addr_d;
            w_hold_q <= w_hold_d;
            w_data_q <= w_data_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // timer core
    // timer input is the instruction clock: one enable every PTM_INSTR_CLK_DIV cycles
    always_comb begin
        case (ctl_q.pre_divide_select) // [R2]
            2'b00: pre_last = 6'h00;
            2'b01: pre_last = `PTM_PRE_DIV4_LAST;
            2'b10: pre_last = `PTM_PRE_DIV16_LAST;
            default: pre_last = `PTM_PRE_DIV64_LAST;
        endcase
    end

    assign scaler_clr = wr_ctl || wr_cnt; // [R8]

    ptm_scaler #(.WIDTH(6)) u_pre (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_clr(scaler_clr),
        .i_en(instr_phase_q && ctl_q.count_run_enable), // [R5]
        .i_last(pre_last),
        .o_tick(pre_tick)
    );

    always_comb begin
        ctl_d = ctl_q;
        count_value_d = count_value_q;
        period_value_d = period_value_q;
        post_cnt_d = post_cnt_q;
        match_pend_d = match_pend_q;
        pulse_d = pulse_q;
        match_event_flag_d = match_event_flag_q;
        match_event_enable_d = match_event_enable_q;
        instr_phase_d = !instr_phase_q;
        flag_set = 1'b0;
        if (pre_tick) begin
            pulse_d = 1'b0;
            if (match_pend_q) begin
                count_value_d = 8'h00; // [R7]
                match_pend_d = 1'b0;
            end else begin
                count_value_d = count_value_q + 8'h01; // [R5]
            end
            if (count_value_d == period_value_q) begin // [R7]
                match_pend_d = 1'b1;
                pulse_d = 1'b1;
                if (post_cnt_q >= ctl_q.post_divide_select) begin // [R6]
                    post_cnt_d = 4'h0;
                    match_event_flag_d = 1'b1;
                    flag_set = 1'b1;
                end else begin
                    post_cnt_d = post_cnt_q + 4'h1;
                end
            end
        end
        if (!ctl_q.count_run_enable) begin
            pulse_d = 1'b0;
        end
        // software clear loses to a same-cycle hardware set
        // keyed on the set event itself, so an already-set flag with no new set is still cleared
        if (wr_sts && wr_byte[`PTM_IRQ_MATCH_BIT] && !flag_set) begin
            match_event_flag_d = 1'b0;
        end
        if (wr_msk) begin
            match_event_enable_d = wr_byte[`PTM_IRQ_MATCH_BIT];
        end
        if (wr_ctl) begin
            ctl_d = wr_byte[6:0]; // [R1] [R3]
            post_cnt_d = 4'h0; // [R8]
        end
        if (wr_cnt) begin
            count_value_d = wr_byte; // [R4]
            post_cnt_d = 4'h0; // [R8]
            match_pend_d = 1'b0;
        end
        if (wr_per) begin
            period_value_d = wr_byte; // [R4]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctl_q <= 7'(`PTM_RST_CONTROL); // [R3]
            count_value_q <= `PTM_RST_COUNT; // [R9]
            period_value_q <= `PTM_RST_PERIOD; // [R9]
            post_cnt_q <= 4'h0;
            match_pend_q <= 1'b0;
            pulse_q <= 1'b0;
            instr_phase_q <= 1'b0;
            match_event_flag_q <= 1'b0;
            match_event_enable_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            count_value_q <= count_value_d;
            period_value_q <= period_value_d;
            post_cnt_q <= post_cnt_d;
            match_pend_q <= match_pend_d;
            pulse_q <= pulse_d;
            instr_phase_q <= instr_phase_d;
            match_event_flag_q <= match_event_flag_d;
            match_event_enable_q <= match_event_enable_d;
        end
    end

    // match pulse lasts one scaled timer period
    assign o_period_match_pulse = pulse_q;
    assign o_irq = match_event_flag_q && match_event_enable_q;

    // ==========================================================
    // assertions
    a_ctl_msb_zero: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R1]
        rvalid_q && $past(i_arvalid && !rvalid_q && i_araddr[11:2] == 10'h000) |-> !rdata_q[7])
        else $error("control bit 7 read as one");
    a_pre_div_four: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R2]
        pre_tick && ctl_q.pre_divide_select == 2'b01 && ctl_q.count_run_enable && !scaler_clr
        ##1 (!scaler_clr && ctl_q.pre_divide_select == 2'b01 && ctl_q.count_run_enable)[*7]
        |=> pre_tick)
        else $error("divide by four tick spacing wrong");
    a_ctl_reset_zero: assert property (@(posedge i_clk_sys) // [R3]
        $past(i_srst) |-> ctl_q == 7'h00 && count_value_q == 8'h00)
        else $error("control or count not cleared by reset");
    a_period_reset: assert property (@(posedge i_clk_sys) $past(i_srst) |-> period_value_q == 8'hff) // [R9]
        else $error("period not all ones after reset");
    a_count_write: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R4]
        wr_cnt |=> count_value_q == $past(wr_byte))
        else $error("count write not stored");
    a_stop_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R5]
        !ctl_q.count_run_enable && !wr_cnt |=> count_value_q == $past(count_value_q))
        else $error("count moved while stopped");
    a_match_reload: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R7]
        pre_tick && match_pend_q && !wr_cnt |=> count_value_q == 8'h00)
        else $error("count not reloaded after match");
    a_ctl_keeps_count: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R8]
        wr_ctl && !wr_cnt && !pre_tick |=> count_value_q == $past(count_value_q) && post_cnt_q == 4'h0)
        else $error("control write disturbed count or postscaler");
    a_post_one_to_one: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R6]
        pre_tick && !wr_ctl && !wr_cnt && ctl_q.post_divide_select == 4'h0
        && count_value_d == period_value_q |=> match_event_flag_q)
        else $error("1:1 postscale did not set flag");
    a_run_advance: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R5]
        pre_tick && !match_pend_q && !wr_cnt |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("count did not advance on prescaled tick");
    a_idle_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R5]
        !pre_tick && !wr_cnt |=> count_value_q == $past(count_value_q))
        else $error("count moved without a prescaled tick");
    a_match_pulse: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R7]
        pre_tick && !wr_cnt && count_value_d == period_value_q |=> pulse_q && match_pend_q)
        else $error("match did not raise pulse and arm reload");
    a_pulse_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R7]
        pulse_q && !pre_tick && ctl_q.count_run_enable |=> pulse_q)
        else $error("match pulse shorter than one timer period");
    a_pend_cancel: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R7]
        wr_cnt |=> !match_pend_q)
        else $error("count write left a reload pending");
    a_cnt_write_post: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R8]
        wr_cnt |=> post_cnt_q == 4'h0)
        else $error("count write did not clear postscaler");
    a_period_write: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R4]
        wr_per |=> period_value_q == $past(wr_byte))
        else $error("period write not stored");
    a_ctl_write: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R3]
        wr_ctl |=> ctl_q == $past(wr_byte[6:0]))
        else $error("control write not stored");
    a_flag_with_pulse: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R6]
        $rose(match_event_flag_q) |-> pulse_q)
        else $error("match flag rose without a match pulse");
    a_set_beats_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R6]
        flag_set |=> match_event_flag_q)
        else $error("hardware set lost to software clear");
    a_flag_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R6]
        wr_sts && wr_byte[`PTM_IRQ_MATCH_BIT] && !flag_set |=> !match_event_flag_q)
        else $error("write one did not clear match flag");
    a_post_counts: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R6]
        pre_tick && !wr_ctl && !wr_cnt && count_value_d == period_value_q
        && post_cnt_q < ctl_q.post_divide_select |=> post_cnt_q == $past(post_cnt_q) + 4'h1)
        else $error("postscaler did not count a match");
    a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        rvalid_q && $past(i_arvalid && !rvalid_q && !addr_known({i_araddr[11:2], 2'b00}))
        |-> rdata_q == 32'h0000_0000 && rresp_q == PTM_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_count_readback: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [R4]
        rvalid_q && $past(i_arvalid && !rvalid_q && {i_araddr[11:2], 2'b00} == `PTM_OFS_COUNT)
        |-> rdata_q[7:0] == $past(count_value_q))
        else $error("count read returned wrong value");
endmodule

// ===== tb/ptm_timer_tb.sv
`timescale 1ns/1ns
`include "ptm_regs.svh"
module ptm_timer_tb
    import ptm_pkg::*;
;
    // ==========================================
    // signals
    localparam logic [11:0] CTL = `PTM_OFS_CONTROL;
    localparam logic [11:0] CNT = `PTM_OFS_COUNT;
    localparam logic [11:0] PER = `PTM_OFS_PERIOD;
    localparam logic [11:0] STAT = `PTM_OFS_IRQ_STATUS;
    localparam logic [11:0] MSK = `PTM_OFS_IRQ_MASK;
    localparam logic [1:0] OK = PTM_RESP_OKAY;
    localparam logic [1:0] ERR = PTM_RESP_SLVERR;
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready, pprev = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pulse, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] expq[$];
    logic [7:0] v;
    int miscompares, num_checks, t1, t2, t3, c, n, k, i, cyc = 0;

    ptm_timer uut (.i_clk_sys(clk), .i_srst(srst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_period_match_pulse(pulse), .o_irq(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================
    // comparison and read monitor
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    always @(posedge clk) begin
        pprev <= pulse;
        cyc <= cyc + 1;
        if (rvalid && rready && expq.size() > 0) begin
            chk({rresp, rdata}, expq.pop_front());
        end
    end

    // ==========================================
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int m;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (m = 0; m < 100; m++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (m == 100) miscompares++;
        chk({32'h0, bresp}, {32'h0, r});
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int m;
        expq.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (m = 0; m < 100; m++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (m == 100) miscompares++;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // waits for the match pulse to change to lvl; returns the cycle stamp
    task automatic edge_wait(input logic lvl, output int t);
        int m;
        for (m = 0; m < 3000; m++) begin
            @(posedge clk);
            if (pulse === lvl && pprev !== lvl) break;
        end
        if (m == 3000) miscompares++;
        t = cyc;
    endtask

    task automatic rst_vals;
        rd(CTL, 8'h00, OK);
        rd(CNT, 8'h00, OK);
        rd(PER, 8'hff, OK);
        rd(STAT, 8'h00, OK);
        rd(MSK, 8'h00, OK);
    endtask

    task automatic close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        close_out();
    end

    // ==========================================
    // main sequence
    initial begin
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(32'h8b528c2d));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rst_vals();
        wr(CTL, 8'hff, OK);
        rd(CTL, 8'h7f, OK);
        rd(12'h014, 8'h00, ERR);
        wr(12'h014, 8'h55, ERR);
        v = 8'($urandom);
        wr(PER, v, OK);
        rd(PER, v, OK);
        // stopped count holds a written value, and a control write keeps it
        v = 8'($urandom);
        wr(CTL, 8'h00, OK);
        wr(CNT, v, OK);
        wr(CTL, 8'h78, OK);
        repeat (40) @(posedge clk);
        rd(CNT, v, OK);
        rd(CTL, 8'h78, OK);
        // interval between matches and pulse width for every prescale code
        for (c = 0; c < 4; c++) begin
            wr(CTL, 8'h00, OK);
            wr(PER, 8'h03, OK);
            wr(CNT, 8'h00, OK);
            wr(CTL, 8'h04 | 8'(c), OK);
            edge_wait(1'b1, t1);
            edge_wait(1'b0, t2);
            edge_wait(1'b1, t3);
            chk(34'(t2 - t1), 34'(2 << (2 * c)));
            chk(34'(t3 - t1), 34'(8 << (2 * c)));
        end
        // every postscale code: irq after code+1 matches; period 2 keeps the first match inside the watch
        wr(CTL, 8'h00, OK);
        wr(PER, 8'h02, OK);
        wr(MSK, 8'h01, OK);
        for (c = 0; c < 16; c++) begin
            wr(CTL, 8'h00, OK);
            wr(CNT, 8'h00, OK);
            wr(STAT, 8'h01, OK);
            chk({33'h0, irq}, 34'h0);
            wr(CTL, {1'b0, 4'(c), 3'b100}, OK);
            n = 0;
            k = 0;
            // a few edges past irq so a pulse landing just after it is counted
            for (i = 0; i < 400 && k < 3; i++) begin
                @(posedge clk);
                if (pulse && !pprev) n++;
                if (irq === 1'b1 || k > 0) k++;
            end
            chk(34'(n), 34'(c + 1));
        end
        // mask hides a set flag; write-one clears it
        wr(MSK, 8'h00, OK);
        repeat (10) @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        wr(CTL, 8'h00, OK);
        rd(STAT, 8'h01, OK);
        wr(STAT, 8'h01, OK);
        rd(STAT, 8'h00, OK);
        // reset in mid-run
        wr(CTL, 8'h7c, OK);
        repeat (30) @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rst_vals();
        close_out();
    end
endmodule
